// ===== src/meas_pkg.sv
// package: constants for the measurement back end
package meas_pkg;
  localparam int          DATA_W        = 24;
  localparam int          OSR_W         = 3;
  localparam int          IIR_W         = 3;
  // base conversion slot per oversampling step, in ns
  localparam int          T_SAMPLE_NS   = 1000;
  localparam int          CLK_NS        = 10;
  localparam int          SAMPLE_CYC    = (T_SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  // reconfiguration delays, in ns
  localparam int          T_RECONF_NS   = 20000;
  localparam int          T_RECONF_D_NS = 40000;
  localparam int          RECONF_CYC    = (T_RECONF_NS + CLK_NS - 1) / CLK_NS;
  localparam int          RECONF_D_CYC  = (T_RECONF_D_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CNT_W         = 20;
  localparam logic [1:0]  FRAME_DIS     = 2'h0;
  localparam logic [1:0]  FRAME_T       = 2'h1;
  localparam logic [1:0]  FRAME_P       = 2'h2;
  localparam logic [1:0]  FRAME_PT      = 2'h3;
  localparam logic [1:0]  MODE_STANDBY  = 2'h0;
  localparam logic [1:0]  MODE_NORMAL   = 2'h1;
  localparam logic [1:0]  MODE_FORCED   = 2'h2;
  localparam logic [1:0]  MODE_CONT     = 2'h3;
  // select bit positions in the five-bit source select
  localparam int          SEL_REG_T     = 0;
  localparam int          SEL_FIFO_T    = 1;
  localparam int          SEL_REG_P     = 2;
  localparam int          SEL_FIFO_P    = 3;
  localparam int          SEL_OOR_P     = 4;
  localparam logic [23:0] DATA_RST      = 24'h000000;
endpackage

// ===== src/iir_if.sv
// interface: one filter channel between sequencer and filter
interface iir_if;
  logic                      flush;
  logic                      load;
  logic [meas_pkg::IIR_W-1:0] coef_code;
  logic [meas_pkg::DATA_W-1:0] raw;
  logic [meas_pkg::DATA_W-1:0] filt;
  modport ctrl (output flush, load, coef_code, raw, input filt);
  modport filt_side (input flush, load, coef_code, raw, output filt);
endinterface

// ===== src/iir_channel.sv
// module: first-order low-pass filter for one channel
module iir_channel (
  input  wire logic mclk,
  input  wire logic rst_b,
  iir_if.filt_side  ch
);
  logic [meas_pkg::DATA_W-1:0] state;
  logic [meas_pkg::DATA_W-1:0] next_state;
  logic                        primed;
  logic                        next_primed;
  logic [6:0]                  coef;
  logic [31:0]                 acc;

  always_comb begin
    // code n selects coefficient 2^n - 1, so divide by 2^n
    coef = 7'((8'h01 << ch.coef_code) - 8'h01);
    acc = 32'(state) * 32'(coef) + 32'(ch.raw);
    next_state = state;
    next_primed = primed;
    if (ch.flush) begin
      next_primed = 1'b0;
    end
    if (ch.load) begin
      if (!primed || ch.flush || ch.coef_code == 3'h0) begin
        next_state = ch.raw;
      end else begin
        next_state = 24'(acc >> ch.coef_code);
      end
      next_primed = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state  <= meas_pkg::DATA_RST;
      primed <= 1'b0;
    end else begin
      state  <= next_state;
      primed <= next_primed;
    end
  end

  assign ch.filt = state;

  filt_first_a: assert property (@(posedge mclk)
    disable iff (!rst_b) (ch.load && (ch.flush || !primed)) |=>
    state == $past(ch.raw)) else $error("first sample not loaded");
  filt_hold_a: assert property (@(posedge mclk)
    disable iff (!rst_b) !ch.load |=> state == $past(state))
    else $error("filter state moved without a sample");
endmodule

// ===== src/meas_backend.sv
// module: measurement sequencing, filtering, source select and shadowing
// Operation
// - pressure plus temperature when enabled or selected
// - pressure never converted without temperature
// - conversion time scales with oversampling factor
// - two 3-bit oversampling fields, x1 to x128
// - config change restarts after reconfiguration delay
// - filter averages previous state with new sample
// - per-channel coefficient code, zero bypasses
// - filters reset on entering normal or continuous
// - flush bit resets filter state
// - five bits select filtered or raw data
// - result registers hold latest measurement
// - temperature 24-bit, 16 fractional bits
// - pressure 24-bit, 6 fractional bits
// - results during burst read go to shadow
// - burst end copies shadow to visible
// - frame selector encodes fifo content
module meas_backend (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [1:0]  pwr_mode,
  input  wire logic        deep_active,
  input  wire logic        press_en,
  input  wire logic [1:0]  frame_sel,
  input  wire logic [2:0]  osr_t,
  input  wire logic [2:0]  osr_p,
  input  wire logic [4:0]  odr,
  input  wire logic        odr_tick,
  input  wire logic [2:0]  iir_t,
  input  wire logic [2:0]  iir_p,
  input  wire logic [4:0]  src_sel,
  input  wire logic        iir_flush,
  input  wire logic        adc_valid,
  input  wire logic [23:0] adc_data,
  input  wire logic        burst_active,
  output logic             adc_start,
  output logic             adc_is_press,
  output logic             meas_busy,
  output logic             press_active,
  output logic             meas_done,
  output logic [7:0]       temp_result_hi,
  output logic [7:0]       temp_result_mid,
  output logic [7:0]       temp_result_lo,
  output logic [7:0]       press_result_hi,
  output logic [7:0]       press_result_mid,
  output logic [7:0]       press_result_lo,
  output logic [23:0]      fifo_temp,
  output logic [23:0]      fifo_press,
  output logic [23:0]      oor_press
);
  // ****************************************
  // types and helpers
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_RECONF = 5'b00010,
    ST_CONV_T = 5'b00100,
    ST_CONV_P = 5'b01000,
    ST_WAIT   = 5'b10000
  } seq_t;

  // oversampling code to cycle count: x1..x128 times one slot
  function automatic logic [19:0] conv_cycles(input logic [2:0] code);
    conv_cycles = 20'(meas_pkg::SAMPLE_CYC) << code;
  endfunction

  function automatic logic active_mode(input logic [1:0] m);
    active_mode = (m == meas_pkg::MODE_NORMAL) || (m == meas_pkg::MODE_CONT);
  endfunction

  iir_if ch_t ();
  iir_if ch_p ();

  iir_channel u_iir_t (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ch    (ch_t)
  );
  iir_channel u_iir_p (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ch    (ch_p)
  );

  // ****************************************
  // sequencer
  // ****************************************
  seq_t         state;
  seq_t         next_state;
  logic [19:0]  cnt;
  logic [19:0]  next_cnt;
  logic [1:0]   prev_mode;
  logic [11:0]  prev_cfg;
  logic         both;
  logic         cfg_change;
  logic         enter_active;
  logic         forced_pend;
  logic         next_forced_pend;
  logic         done_pulse;
  logic         next_done;
  logic [23:0]  t_raw;
  logic [23:0]  next_t_raw;

  always_comb begin
    // pressure conversion implies temperature conversion
    both = press_en || frame_sel == meas_pkg::FRAME_P
        || frame_sel == meas_pkg::FRAME_PT;
    enter_active = active_mode(pwr_mode) && !active_mode(prev_mode);
    // odr only counts in normal mode
    cfg_change = active_mode(pwr_mode) && active_mode(prev_mode) &&
      (prev_cfg != {press_en, osr_t, osr_p,
        pwr_mode == meas_pkg::MODE_NORMAL ? odr : prev_cfg[4:0]});
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_forced_pend = forced_pend;
    next_done = 1'b0;
    next_t_raw = t_raw;
    adc_start = 1'b0;
    adc_is_press = 1'b0;
    ch_t.load = 1'b0;
    ch_p.load = 1'b0;
    if (pwr_mode == meas_pkg::MODE_FORCED && prev_mode != pwr_mode) begin
      next_forced_pend = 1'b1;
    end
    if (cfg_change) begin
      // restart with new settings after the reconfiguration delay
      next_state = ST_RECONF;
      next_cnt = deep_active ? 20'(meas_pkg::RECONF_D_CYC)
                             : 20'(meas_pkg::RECONF_CYC);
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (enter_active || next_forced_pend) begin
            next_state = ST_CONV_T;
            next_cnt = conv_cycles(osr_t);
            next_forced_pend = 1'b0;
            adc_start = 1'b1;
          end
        end
        ST_RECONF: begin
          if (cnt <= 20'h1) begin
            next_state = ST_CONV_T;
            next_cnt = conv_cycles(osr_t);
            adc_start = 1'b1;
          end else begin
            next_cnt = cnt - 20'h1;
          end
        end
        ST_CONV_T: begin
          if (cnt != 20'h0) begin
            next_cnt = cnt - 20'h1;
          end
          if (adc_valid && cnt == 20'h0) begin
            next_t_raw = adc_data;
            if (both) begin
              next_state = ST_CONV_P;
              next_cnt = conv_cycles(osr_p);
              adc_start = 1'b1;
              adc_is_press = 1'b1;
            end else begin
              ch_t.load = 1'b1;
              next_done = 1'b1;
              next_state = ST_WAIT;
            end
          end
        end
        ST_CONV_P: begin
          adc_is_press = 1'b1;
          if (cnt != 20'h0) begin
            next_cnt = cnt - 20'h1;
          end
          if (adc_valid && cnt == 20'h0) begin
            // both channels complete together
            ch_t.load = 1'b1;
            ch_p.load = 1'b1;
            next_done = 1'b1;
            next_state = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (pwr_mode == meas_pkg::MODE_CONT ||
              (pwr_mode == meas_pkg::MODE_NORMAL && odr_tick)) begin
            next_state = ST_CONV_T;
            next_cnt = conv_cycles(osr_t);
            adc_start = 1'b1;
          end else if (!active_mode(pwr_mode)) begin
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      cnt         <= 20'h0;
      prev_mode   <= meas_pkg::MODE_STANDBY;
      prev_cfg    <= 12'h000;
      forced_pend <= 1'b0;
      done_pulse  <= 1'b0;
      t_raw       <= meas_pkg::DATA_RST;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      prev_mode   <= pwr_mode;
      prev_cfg    <= {press_en, osr_t, osr_p,
        pwr_mode == meas_pkg::MODE_NORMAL ? odr : prev_cfg[4:0]};
      forced_pend <= next_forced_pend;
      done_pulse  <= next_done;
      t_raw       <= next_t_raw;
    end
  end

  // filters: reset on entry to an active mode or by the flush bit
  assign ch_t.flush = enter_active || iir_flush;
  assign ch_p.flush = enter_active || iir_flush;
  assign ch_t.coef_code = iir_t;
  assign ch_p.coef_code = iir_p;
  assign ch_t.raw = (state == ST_CONV_P) ? t_raw : adc_data;
  assign ch_p.raw = adc_data;

  assign meas_busy = state != ST_IDLE && state != ST_WAIT;
  assign press_active = both;
  assign meas_done = done_pulse;

  // ****************************************
  // source select and shadowing
  // ****************************************
  logic [23:0] raw_t_q;
  logic [23:0] raw_p_q;
  logic [23:0] next_raw_t;
  logic [23:0] next_raw_p;
  logic [23:0] vis_t;
  logic [23:0] vis_p;
  logic [23:0] shd_t;
  logic [23:0] shd_p;
  logic [23:0] next_vis_t;
  logic [23:0] next_vis_p;
  logic [23:0] next_shd_t;
  logic [23:0] next_shd_p;
  logic        shd_pend;
  logic        next_shd_pend;
  logic        p_done;
  logic        next_p_done;
  logic [23:0] sel_t;
  logic [23:0] sel_p;

  always_comb begin
    next_raw_t = ch_t.load ? ch_t.raw : raw_t_q;
    next_raw_p = ch_p.load ? ch_p.raw : raw_p_q;
    next_p_done = ch_p.load ? 1'b1 : (ch_t.load ? 1'b0 : p_done);
    sel_t = src_sel[meas_pkg::SEL_REG_T] ? ch_t.filt : raw_t_q;
    sel_p = src_sel[meas_pkg::SEL_REG_P] ? ch_p.filt : raw_p_q;
    next_vis_t = vis_t;
    next_vis_p = vis_p;
    next_shd_t = shd_t;
    next_shd_p = shd_p;
    next_shd_pend = shd_pend;
    if (done_pulse) begin
      if (burst_active) begin
        next_shd_t = sel_t;
        next_shd_p = p_done ? sel_p : (shd_pend ? shd_p : vis_p);
        next_shd_pend = 1'b1;
      end else begin
        next_vis_t = sel_t;
        next_vis_p = p_done ? sel_p : (shd_pend ? shd_p : vis_p);
        next_shd_pend = 1'b0;
      end
    end else if (shd_pend && !burst_active) begin
      // bus transaction over: copy everything at once
      next_vis_t = shd_t;
      next_vis_p = shd_p;
      next_shd_pend = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      raw_t_q  <= meas_pkg::DATA_RST;
      raw_p_q  <= meas_pkg::DATA_RST;
      vis_t    <= meas_pkg::DATA_RST;
      vis_p    <= meas_pkg::DATA_RST;
      shd_t    <= meas_pkg::DATA_RST;
      shd_p    <= meas_pkg::DATA_RST;
      shd_pend <= 1'b0;
      p_done   <= 1'b0;
    end else begin
      raw_t_q  <= next_raw_t;
      raw_p_q  <= next_raw_p;
      vis_t    <= next_vis_t;
      vis_p    <= next_vis_p;
      shd_t    <= next_shd_t;
      shd_p    <= next_shd_p;
      shd_pend <= next_shd_pend;
      p_done   <= next_p_done;
    end
  end

  // temperature has 16 fraction bits, pressure 6; bytes split as stored
  assign temp_result_hi   = vis_t[23:16];
  assign temp_result_mid  = vis_t[15:8];
  assign temp_result_lo   = vis_t[7:0];
  assign press_result_hi  = vis_p[23:16];
  assign press_result_mid = vis_p[15:8];
  assign press_result_lo  = vis_p[7:0];
  assign fifo_temp  = src_sel[meas_pkg::SEL_FIFO_T] ? ch_t.filt : raw_t_q;
  assign fifo_press = src_sel[meas_pkg::SEL_FIFO_P] ? ch_p.filt : raw_p_q;
  assign oor_press  = src_sel[meas_pkg::SEL_OOR_P]  ? ch_p.filt : raw_p_q;

  shadow_hold_a: assert property (@(posedge mclk)
    disable iff (!rst_b) (burst_active && $past(burst_active))
    |-> $stable(vis_t)) else $error("visible data changed during burst");
  shadow_copy_a: assert property (@(posedge mclk)
    disable iff (!rst_b) (shd_pend && !burst_active && !done_pulse)
    |=> vis_t == $past(shd_t)) else $error("shadow not copied at burst end");
  press_needs_temp_a: assert property (@(posedge mclk)
    disable iff (!rst_b) state == ST_CONV_P |-> $past(state) inside
    {ST_CONV_T, ST_CONV_P}) else $error("pressure without temperature");
  reconf_delay_a: assert property (@(posedge mclk)
    disable iff (!rst_b) cfg_change |=> state == ST_RECONF)
    else $error("config change did not restart");
  conv_len_a: assert property (@(posedge mclk)
    disable iff (!rst_b) (adc_start && !adc_is_press) |=>
    cnt == conv_cycles($past(osr_t))) else $error("conversion length wrong");
endmodule

// ===== testbench/host_model.sv
// host model: reads every result byte in one bus transaction
module host_model (
  input  wire logic        mclk,
  input  wire logic [23:0] t_val,
  input  wire logic [23:0] p_val,
  output logic             burst_active
);
  timeunit 1ns;
  timeprecision 100ps;

  initial burst_active = 1'b0;

  // one transaction covers all six bytes, so they stay from one measurement
  task automatic read_burst(input int len, output logic [47:0] first, last);
    @(posedge mclk);
    #1 burst_active = 1'b1;
    first = {t_val, p_val};
    repeat (len) @(posedge mclk);
    last = {t_val, p_val};
    #1 burst_active = 1'b0;
  endtask
endmodule

// ===== testbench/measurement_iir_data_shadow_tb.sv
// testbench: sequencing, filter, source select and shadowing checks
module measurement_iir_data_shadow_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst_b, deep_active, press_en, odr_tick, iir_flush;
  logic        burst_active, go, ip;
  logic        adc_valid = 1'b0;
  logic [23:0] adc_data = 24'h000000;
  logic        adc_start, adc_is_press, meas_busy, press_active, meas_done;
  logic [1:0]  pwr_mode, frame_sel;
  logic [2:0]  osr_t, osr_p, iir_t, iir_p;
  logic [4:0]  odr, src_sel;
  logic [7:0]  temp_result_hi, temp_result_mid, temp_result_lo;
  logic [7:0]  press_result_hi, press_result_mid, press_result_lo;
  logic [23:0] fifo_temp, fifo_press, oor_press, temp_v, press_v;
  logic [23:0] t_q[$], p_q[$];
  int          failures = 0;
  int          n_tests = 0;
  int          n_press = 0;
  assign temp_v  = {temp_result_hi, temp_result_mid, temp_result_lo};
  assign press_v = {press_result_hi, press_result_mid, press_result_lo};

  meas_backend u_meas_backend (
    .mclk, .rst_b, .pwr_mode, .deep_active, .press_en, .frame_sel,
    .osr_t, .osr_p, .odr, .odr_tick, .iir_t, .iir_p, .src_sel, .iir_flush,
    .adc_valid, .adc_data, .burst_active, .adc_start, .adc_is_press,
    .meas_busy, .press_active, .meas_done, .temp_result_hi,
    .temp_result_mid, .temp_result_lo, .press_result_hi,
    .press_result_mid, .press_result_lo, .fifo_temp, .fifo_press, .oor_press
  );
  host_model u_host_model (.mclk, .t_val(temp_v), .p_val(press_v),
    .burst_active);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ********************
  // converter stand-in
  // ********************
  // an early result is offered at half time: it must be ignored
  always begin : adc_resp
    logic [23:0] d;
    int n;
    @(posedge mclk);
    go = adc_start;
    ip = adc_is_press;
    while (go === 1'b1) begin
      n = meas_pkg::SAMPLE_CYC << (ip ? osr_p : osr_t);
      if (ip === 1'b1) begin
        n_press++;
        d = p_q.size() ? p_q.pop_front() : 24'h000000;
      end else begin
        d = t_q.size() ? t_q.pop_front() : 24'h000000;
      end
      repeat (n / 2) @(posedge mclk);
      #1 adc_valid = 1'b1;
      adc_data = ~d;
      @(posedge mclk);
      #1 adc_valid = 1'b0;
      repeat (n / 2) @(posedge mclk);
      #1 adc_valid = 1'b1;
      adc_data = d;
      @(posedge mclk);
      go = adc_start;
      ip = adc_is_press;
      #1 adc_valid = 1'b0;
    end
  end

  // ********************
  // shared tasks
  // ********************
  task automatic chk_val(input string name, input logic [23:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %s expected %h got %h", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int exp, got);
    n_tests++;
    if (got != exp) begin
      failures++;
      $display("FAIL %s expected %0d got %0d", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wait_done(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge mclk);
      if (meas_done === 1'b1) break;
    end
    #1;
    chk_cnt("done_seen", 1, int'(i < lim));
  endtask

  task automatic wait_start(input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(posedge mclk);
      if (adc_start === 1'b1) break;
    end
    #1;
  endtask

  task automatic stop;
    pwr_mode = meas_pkg::MODE_STANDBY;
    // a continuous run may still be converting: let it finish first
    for (int i = 0; i < 600 && meas_busy !== 1'b0; i++) begin
      tick(1);
    end
    chk_cnt("stop_idle", 0, int'(meas_busy !== 1'b0));
    tick(130);
    t_q.delete();
    p_q.delete();
  endtask

  task automatic forced(input int lim);
    pwr_mode = meas_pkg::MODE_FORCED;
    wait_done(lim);
    stop;
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_reset;
    chk_val("temp_rst", meas_pkg::DATA_RST, temp_v);
    chk_val("press_rst", meas_pkg::DATA_RST, press_v);
    chk_val("oor_rst", meas_pkg::DATA_RST, oor_press);
  endtask

  task automatic t_forced;
    for (int k = 0; k < 8; k++) begin
      logic [23:0] tv, pv, pold;
      logic        pp;
      int          np;
      osr_t = k[2:0];
      osr_p = 3'h7 - k[2:0];
      frame_sel = k[1:0];
      press_en = k[2];
      pp = k[2] | k[1];
      tv = {8'(k), 16'h00a5};
      pv = {16'h0186, 8'(k)};
      pold = press_v;
      t_q.push_back(tv);
      if (pp) p_q.push_back(pv);
      np = n_press;
      forced((meas_pkg::SAMPLE_CYC << k)
        + (meas_pkg::SAMPLE_CYC << (7 - k)) + 20);
      chk_val("temp_res", tv, temp_v);
      chk_val("press_res", pp ? pv : pold, press_v);
      chk_cnt("press_conv", int'(pp), n_press - np);
      chk_cnt("p_act", int'(pp), int'(press_active === 1'b1));
    end
  endtask

  task automatic t_filter;
    for (int c = 0; c < 8; c++) begin
      logic [23:0] bt, bp;
      iir_t = c[2:0];
      iir_p = 3'h7 - c[2:0];
      src_sel = c[0] ? 5'h15 : 5'h0a;
      {osr_t, osr_p, press_en, frame_sel} = {3'h0, 3'h0, 1'b1, 2'h0};
      bt = 24'h100000 + (24'h000100 << c);
      bp = 24'h200000 + (24'h000040 << (7 - c));
      t_q = '{24'h100000, bt};
      p_q = '{24'h200000, bp};
      pwr_mode = meas_pkg::MODE_CONT;
      wait_done(300);
      wait_done(300);
      tick(2);
      chk_val("reg_t", src_sel[0] ? 24'h100100 : bt, temp_v);
      chk_val("fifo_t", src_sel[1] ? 24'h100100 : bt, fifo_temp);
      chk_val("reg_p", src_sel[2] ? 24'h200040 : bp, press_v);
      chk_val("fifo_p", src_sel[3] ? 24'h200040 : bp, fifo_press);
      chk_val("oor_p", src_sel[4] ? 24'h200040 : bp, oor_press);
      stop;
    end
  endtask

  task automatic t_flush;
    logic [23:0] raw [3] = '{24'h100000, 24'h300000, 24'h050000};
    logic [23:0] exp [3] = '{24'h100000, 24'h200000, 24'h050000};
    {iir_t, press_en, src_sel} = {3'h1, 1'b0, 5'h1f};
    for (int i = 0; i < 3; i++) begin
      iir_flush = (i != 1);
      tick(1);
      iir_flush = 1'b0;
      t_q.push_back(raw[i]);
      forced(300);
      chk_val("flush_t", exp[i], temp_v);
    end
  endtask

  task automatic t_shadow;
    logic [47:0] old, first, last;
    {iir_t, iir_p, src_sel, press_en} = {3'h0, 3'h0, 5'h00, 1'b1};
    old = {temp_v, press_v};
    t_q.push_back(24'h0abcde);
    p_q.push_back(24'h00fedc);
    pwr_mode = meas_pkg::MODE_FORCED;
    fork
      u_host_model.read_burst(300, first, last);
      begin
        wait_done(300);
        pwr_mode = meas_pkg::MODE_STANDBY;
      end
    join
    chk_val("burst_t0", old[47:24], first[47:24]);
    chk_val("burst_t1", old[47:24], last[47:24]);
    chk_val("burst_p1", old[23:0], last[23:0]);
    tick(2);
    chk_val("after_t", 24'h0abcde, temp_v);
    chk_val("after_p", 24'h00fedc, press_v);
  endtask

  task automatic t_restart;
    int n, e, np;
    {press_en, osr_t, osr_p, odr} = {1'b0, 3'h0, 3'h0, 5'h00};
    pwr_mode = meas_pkg::MODE_NORMAL;
    wait_done(300);
    tick(5);
    odr_tick = 1'b1;
    wait_start(1, n);
    odr_tick = 1'b0;
    if (n != 0) wait_start(4, n);
    chk_cnt("tick_start", 1, int'(n < 4));
    wait_done(300);
    for (int i = 0; i < 3; i++) begin
      case (i)
        0: osr_t = 3'h1;
        1: {deep_active, press_en} = 2'b11;
        // an upper rate bit alone must restart as well
        default: {deep_active, odr} = {1'b0, 5'h08};
      endcase
      np = n_press;
      e = deep_active ? meas_pkg::RECONF_D_CYC : meas_pkg::RECONF_CYC;
      wait_start(meas_pkg::RECONF_D_CYC + 20, n);
      chk_cnt("restart_min", 1, int'(n >= e - 2));
      chk_cnt("restart_max", 1, int'(n <= e + 8));
      wait_done(700);
      chk_cnt("restart_p", int'(press_en), n_press - np);
    end
    stop;
  endtask

  initial begin
    {rst_b, deep_active, press_en, odr_tick, iir_flush} = 5'h00;
    {pwr_mode, frame_sel, osr_t, osr_p} = 10'h000;
    {iir_t, iir_p, odr, src_sel} = 16'h0000;
    tick(10);
    rst_b = 1'b1;
    tick(2);
    t_reset;
    t_forced;
    t_filter;
    t_flush;
    t_shadow;
    t_restart;
    complete_run;
  end

  // bound well above the roughly fifty thousand cycles the tests take
  initial begin
    repeat (95000) @(posedge mclk);
    failures++;
    complete_run;
  end
endmodule
